// [hdl/pwm_irq_pkg.sv]
/*
  Constants for the PWM interrupt, trigger and period block: APB offsets,
  field positions, reset values and event bit positions.
  Assumes a 32-bit APB with 12 address bits and one clock domain.
*/
// Functional notes
// [R1] Writing a one to a generator status bit clears that latched flag.
// [R2] Each generator flags zero, load, and compare A/B while counting up or down.
// [R3] Each generator shows a raw status view and a masked status view.
// [R4] A set interrupt/trigger enable bit unmasks its source, a clear bit masks it.
// [R5] Each generator drives six trigger outputs, each with its own enable bit.
// [R6] A module enable register has one bit per generator and per fault input.
// [R7] Module raw and masked status show generator and fault indications in one field.
// [R8] The period is the number of ticks between successive counter-zero pulses; in up/down mode the code gives one tick less for odd periods above 1.
// [R9] A new period is used only from the next counter zero; reads give the programmed value.
// [R10] Repeated period writes before an update keep only the last one.
// [R11] Masked bit is raw AND enable; a generator indication is the OR of its masked bits.
// [R12] Writing zero leaves a status bit alone; a same-cycle event beats the clear.
package pwm_irq_pkg;
  localparam int NGEN = 4;
  localparam int NFLT = 4;
  localparam int NEVT = 6;
  localparam int PW   = 16;
  localparam int AW   = 12;
  // Module-level registers
  localparam logic [AW-1:0] OFS_MOD_EN  = 12'h000;
  localparam logic [AW-1:0] OFS_MOD_RIS = 12'h004;
  localparam logic [AW-1:0] OFS_MOD_ISC = 12'h008;
  // Generator g block sits at block number GEN_BLK0 + g, 64 bytes each
  localparam logic [5:0]    GEN_BLK0    = 6'h01;
  localparam logic [5:0]    OFS_CTL     = 6'h00;
  localparam logic [5:0]    OFS_PERIOD  = 6'h04;
  localparam logic [5:0]    OFS_CMPA    = 6'h08;
  localparam logic [5:0]    OFS_CMPB    = 6'h0C;
  localparam logic [5:0]    OFS_INTEN   = 6'h10;
  localparam logic [5:0]    OFS_RIS     = 6'h14;
  localparam logic [5:0]    OFS_ISC     = 6'h18;
  localparam logic [5:0]    OFS_COUNT   = 6'h1C;
  // Control fields
  localparam int CTL_RUN    = 0;
  localparam int CTL_UPDOWN = 1;
  localparam int CTL_W      = 2;
  // Event bits in status and enable registers
  localparam int gen_irq_count_at_zero       = 0;
  localparam int gen_irq_count_at_load       = 1;
  localparam int gen_irq_cmp_a_rising_count  = 2;
  localparam int gen_irq_cmp_a_falling_count = 3;
  localparam int gen_irq_cmp_b_rising_count  = 4;
  localparam int gen_irq_cmp_b_falling_count = 5;
  localparam int gen_trig_count_at_zero      = 8;
  localparam int gen_trig_cmp_b_falling_count = 13;
  localparam int INTEN_W = 14;
  // Module status field positions
  localparam int module_irq_generator_zero   = 0;
  localparam int module_irq_fault_input_zero = 16;
  // Reset values
  localparam logic [PW-1:0]      RST_PERIOD = 16'h0000;
  localparam logic [PW-1:0]      RST_CMP    = 16'h0000;
  localparam logic [INTEN_W-1:0] RST_INTEN  = 14'h0000;
  localparam logic [CTL_W-1:0]   RST_CTL    = 2'h0;
endpackage

// [hdl/pwm_gen_counter.sv]
/*
  One PWM generator counter: down or up/down counting, buffered period
  taken at each counter zero, and the six registered event pulses.
  Assumes period and compare values come from registers on the same clock.
*/
`timescale 1ns/10ps
module pwm_gen_counter
  import pwm_irq_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            run,
  input  wire logic            updown,
  input  wire logic [PW-1:0]   period_in,
  input  wire logic [PW-1:0]   cmp_a,
  input  wire logic [PW-1:0]   cmp_b,
  output logic      [PW-1:0]   count,
  output logic      [NEVT-1:0] evt
);

  typedef struct packed {
    logic [PW-1:0]   cnt;
    logic [PW-1:0]   act;
    logic [PW-1:0]   top;
    logic            dir_down;
    logic [NEVT-1:0] evt;
  } gen_state_t;

  gen_state_t st_reg;
  gen_state_t st_next;
  logic [PW-1:0] top_new;
  logic          going_up;

  // Counter walk; period sampled only at zero so it cannot tear mid-cycle
  always_comb
  begin
    st_next  = st_reg;
    st_next.evt = '0;
    going_up = updown && !st_reg.dir_down;
    top_new  = updown ? (period_in >> 1) : ((period_in == '0) ? '0 : period_in - 16'h0001);
    if (!run)
    begin
      st_next.cnt      = '0;
      st_next.dir_down = 1'b0;
    end
    else
    begin
      st_next.evt[gen_irq_count_at_zero]       = (st_reg.cnt == '0); // [R2]
      st_next.evt[gen_irq_count_at_load]       = (st_reg.cnt == st_reg.top);
      st_next.evt[gen_irq_cmp_a_rising_count]  = (st_reg.cnt == cmp_a) && going_up;
      st_next.evt[gen_irq_cmp_a_falling_count] = (st_reg.cnt == cmp_a) && !going_up;
      st_next.evt[gen_irq_cmp_b_rising_count]  = (st_reg.cnt == cmp_b) && going_up;
      st_next.evt[gen_irq_cmp_b_falling_count] = (st_reg.cnt == cmp_b) && !going_up;
      if (st_reg.cnt == '0)
      begin
        st_next.act      = period_in; // [R9] [R10]
        st_next.top      = top_new;
        st_next.dir_down = 1'b0;
        st_next.cnt      = updown ? ((top_new != '0) ? 16'h0001 : '0) : top_new; // [R8]
      end
      else if (going_up && st_reg.cnt >= st_reg.top)
      begin
        st_next.dir_down = 1'b1;
        st_next.cnt      = st_reg.cnt - 16'h0001;
      end
      else if (going_up)
        st_next.cnt = st_reg.cnt + 16'h0001;
      else
        st_next.cnt = st_reg.cnt - 16'h0001;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign count = st_reg.cnt;
  assign evt   = st_reg.evt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_down_reload: assert property (run && !updown && st_reg.cnt == '0 |=> // [R8]
      st_reg.cnt == $past(top_new))
    else $error("down counter did not reload from period");
  a_period_hold: assert property (st_reg.cnt != '0 |=> st_reg.act == $past(st_reg.act)) // [R9]
    else $error("active period changed away from counter zero");
  a_period_take: assert property (run && st_reg.cnt == '0 |=> st_reg.act == $past(period_in)) // [R10]
    else $error("latest period not applied at zero");
endmodule // pwm_gen_counter

// [hdl/pwm_irq_trig_period.sv]
/*
  PWM interrupt, trigger and period block: four generator counters, their
  sticky event status, enables, trigger outputs, module status and the
  APB register slave that reaches all of it.
  Assumes an APB master on clk and fault inputs that are asynchronous pins.
*/
`timescale 1ns/10ps
module pwm_irq_trig_period
  import pwm_irq_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [AW-1:0]             paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [NFLT-1:0]           fault_in,
  output logic      [NGEN-1:0][NEVT-1:0] trig,
  output logic                           irq
);

  typedef struct packed {
    logic [NGEN-1:0][CTL_W-1:0]   ctl;
    logic [NGEN-1:0][PW-1:0]      period;
    logic [NGEN-1:0][PW-1:0]      cmp_a;
    logic [NGEN-1:0][PW-1:0]      cmp_b;
    logic [NGEN-1:0][INTEN_W-1:0] inten;
    logic [NGEN-1:0][NEVT-1:0]    raw;
    logic [NGEN-1:0][NEVT-1:0]    trig;
    logic [NGEN-1:0]              gen_en;
    logic [NFLT-1:0]              flt_en;
    logic [NFLT-1:0]              flt_raw;
    logic [NFLT-1:0]              fsync1;
    logic [NFLT-1:0]              fsync2;
    logic [NFLT-1:0]              fprev;
    logic                         irq;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
  } top_state_t;

  top_state_t st_reg;
  top_state_t st_next;

  logic [NGEN-1:0][NEVT-1:0] gevt;
  logic [NGEN-1:0][PW-1:0]   gcount;
  logic [NGEN-1:0][NEVT-1:0] gmasked;
  logic [NGEN-1:0]           gen_ind;
  logic [31:0]               mod_raw;
  logic [31:0]               mod_masked;
  logic [31:0]               rdata;
  logic                      hit;
  logic                      acc;
  logic                      wr_fire;
  logic                      rd_take;
  logic [5:0]                blk;
  logic [5:0]                ofs;

  // One counter per generator
  genvar g;
  generate
    for (g = 0; g < NGEN; g++)
    begin : gen_cnt
      pwm_gen_counter u_cnt (
        .clk       (clk),
        .rst       (rst),
        .run       (st_reg.ctl[g][CTL_RUN]),
        .updown    (st_reg.ctl[g][CTL_UPDOWN]),
        .period_in (st_reg.period[g]),
        .cmp_a     (st_reg.cmp_a[g]),
        .cmp_b     (st_reg.cmp_b[g]),
        .count     (gcount[g]),
        .evt       (gevt[g])
      );
      // Masked view and module indication per generator
      assign gmasked[g] = st_reg.raw[g] & st_reg.inten[g][NEVT-1:0]; // [R3] [R11]
      assign gen_ind[g] = |gmasked[g]; // [R11]
    end
  endgenerate

  // Module status field: generators low, fault inputs from bit 16
  always_comb
  begin
    mod_raw = '0;
    mod_raw[module_irq_generator_zero +: NGEN]   = gen_ind; // [R7]
    mod_raw[module_irq_fault_input_zero +: NFLT] = st_reg.flt_raw;
    mod_masked = '0;
    mod_masked[module_irq_generator_zero +: NGEN] = gen_ind & st_reg.gen_en; // [R6]
    mod_masked[module_irq_fault_input_zero +: NFLT] = st_reg.flt_raw & st_reg.flt_en;
  end

  // Bus phase decode
  assign acc     = psel && penable;
  assign wr_fire = acc && st_reg.pready && pwrite;
  assign rd_take = acc && !st_reg.pready;
  assign blk     = paddr[AW-1:6];
  assign ofs     = paddr[5:0];

  // Read mux; also flags whether the address is mapped at all
  always_comb
  begin
    rdata = '0;
    hit   = 1'b0;
    case (paddr)
      OFS_MOD_EN:
      begin
        hit = 1'b1;
        rdata[module_irq_generator_zero +: NGEN]   = st_reg.gen_en;
        rdata[module_irq_fault_input_zero +: NFLT] = st_reg.flt_en;
      end
      OFS_MOD_RIS:
      begin
        hit   = 1'b1;
        rdata = mod_raw;
      end
      OFS_MOD_ISC:
      begin
        hit   = 1'b1;
        rdata = mod_masked;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    for (int i = 0; i < NGEN; i++)
    begin
      if (blk == GEN_BLK0 + 6'(i))
      begin
        hit = 1'b1;
        case (ofs)
          OFS_CTL:    rdata[CTL_W-1:0]   = st_reg.ctl[i];
          OFS_PERIOD: rdata[PW-1:0]      = st_reg.period[i]; // [R9]
          OFS_CMPA:   rdata[PW-1:0]      = st_reg.cmp_a[i];
          OFS_CMPB:   rdata[PW-1:0]      = st_reg.cmp_b[i];
          OFS_INTEN:  rdata[INTEN_W-1:0] = st_reg.inten[i];
          OFS_RIS:    rdata[NEVT-1:0]    = st_reg.raw[i]; // [R3]
          OFS_ISC:    rdata[NEVT-1:0]    = gmasked[i]; // [R3]
          OFS_COUNT:  rdata[PW-1:0]      = gcount[i];
          default:    hit = 1'b0;
        endcase
      end
    end
  end

  // Next state: bus slave, register writes, sticky flags, triggers, faults
  always_comb
  begin
    st_next = st_reg;
    // One wait state: data captured in the first access cycle; the error
    // flag covers unmapped writes too, so a dropped write is not silent
    st_next.pready  = rd_take;
    st_next.pslverr = rd_take && !hit;
    st_next.prdata  = rd_take && !pwrite ? rdata : st_reg.prdata;

    // Configuration writes take effect on the completing edge
    if (wr_fire && hit)
    begin
      if (paddr == OFS_MOD_EN)
      begin
        st_next.gen_en = pwdata[module_irq_generator_zero +: NGEN]; // [R6]
        st_next.flt_en = pwdata[module_irq_fault_input_zero +: NFLT];
      end
      for (int i = 0; i < NGEN; i++)
      begin
        if (blk == GEN_BLK0 + 6'(i))
        begin
          case (ofs)
            OFS_CTL:    st_next.ctl[i]    = pwdata[CTL_W-1:0];
            OFS_PERIOD: st_next.period[i] = pwdata[PW-1:0]; // [R10]
            OFS_CMPA:   st_next.cmp_a[i]  = pwdata[PW-1:0];
            OFS_CMPB:   st_next.cmp_b[i]  = pwdata[PW-1:0];
            OFS_INTEN:  st_next.inten[i]  = pwdata[INTEN_W-1:0]; // [R4]
            default:    st_next.ctl[i]    = st_reg.ctl[i];
          endcase
        end
      end
    end

    // Sticky generator flags: clear by one, event wins the same cycle.
    // Clearing first and setting after keeps an event that meets a clear.
    for (int i = 0; i < NGEN; i++)
    begin
      if (wr_fire && blk == GEN_BLK0 + 6'(i) && ofs == OFS_ISC)
        st_next.raw[i] = st_reg.raw[i] & ~pwdata[NEVT-1:0]; // [R1] [R12]
      st_next.raw[i] = st_next.raw[i] | gevt[i]; // [R2] [R12]
      // Trigger pulses gated by their own enables
      st_next.trig[i] = gevt[i] & st_reg.inten[i][gen_trig_cmp_b_falling_count -: NEVT]; // [R5]
    end

    // Fault pins: two-flop sync, then rising edge sets a sticky bit
    st_next.fsync1  = fault_in;
    st_next.fsync2  = st_reg.fsync1;
    st_next.fprev   = st_reg.fsync2;
    st_next.flt_raw = st_reg.flt_raw;
    if (wr_fire && paddr == OFS_MOD_ISC)
      st_next.flt_raw = st_reg.flt_raw & ~pwdata[module_irq_fault_input_zero +: NFLT];
    st_next.flt_raw = st_next.flt_raw | (st_reg.fsync2 & ~st_reg.fprev); // [R12]

    // Level interrupt, one flop behind the status
    st_next.irq = |mod_masked; // [R6] [R7]
  end

  // Whole block state; reset gives constants only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg        <= '0;
      st_reg.ctl    <= {NGEN{RST_CTL}};
      st_reg.period <= {NGEN{RST_PERIOD}};
      st_reg.cmp_a  <= {NGEN{RST_CMP}};
      st_reg.cmp_b  <= {NGEN{RST_CMP}};
      st_reg.inten  <= {NGEN{RST_INTEN}};
    end
    else
      st_reg <= st_next;
  end

  // Outputs straight from the state flops
  assign prdata  = st_reg.prdata;
  assign pready  = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign trig    = st_reg.trig;
  assign irq     = st_reg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Clear of generator 0 zero flag with no new event
  a_clear_w1c: assert property (wr_fire && blk == GEN_BLK0 && ofs == OFS_ISC // [R1]
      && pwdata[gen_irq_count_at_zero] && !gevt[0][gen_irq_count_at_zero]
      |=> !st_reg.raw[0][gen_irq_count_at_zero])
    else $error("write one did not clear generator flag");

  a_event_sets: assert property (gevt[0][gen_irq_count_at_load] // [R2]
      |=> st_reg.raw[0][gen_irq_count_at_load])
    else $error("event did not set raw flag");

  a_zero_keeps: assert property (wr_fire && blk == GEN_BLK0 && ofs == OFS_ISC // [R12]
      && !pwdata[gen_irq_count_at_load] && st_reg.raw[0][gen_irq_count_at_load]
      |=> st_reg.raw[0][gen_irq_count_at_load])
    else $error("writing zero altered a status bit");

  a_masked_read: assert property (rd_take && !pwrite && blk == GEN_BLK0 // [R3]
      && ofs == OFS_ISC |=> pready && prdata[NEVT-1:0] ==
      $past(st_reg.raw[0] & st_reg.inten[0][NEVT-1:0]))
    else $error("masked status read wrong");

  a_trig_gate: assert property (##1 trig[0] == // [R5]
      $past(gevt[0] & st_reg.inten[0][gen_trig_cmp_b_falling_count -: NEVT]))
    else $error("trigger not gated by its enable");

  a_enable_mask: assert property (st_reg.inten[0][gen_irq_count_at_zero] == 1'b0 // [R4]
      |-> !gmasked[0][gen_irq_count_at_zero])
    else $error("disabled source shows in masked view");

  a_gen_ind: assert property (gen_ind[0] == |(st_reg.raw[0] & st_reg.inten[0][NEVT-1:0])) // [R11]
    else $error("generator indication is not OR of masked bits");

  a_irq_level: assert property (##1 irq == $past(|mod_masked)) // [R6]
    else $error("interrupt output does not follow masked status");

  a_period_read: assert property (rd_take && !pwrite && blk == GEN_BLK0 // [R9]
      && ofs == OFS_PERIOD |=> prdata[PW-1:0] == $past(st_reg.period[0]))
    else $error("period read did not return programmed value");

  a_fault_flag: assert property (st_reg.fsync2[2] && !st_reg.fprev[2] // [R7]
      |=> st_reg.flt_raw[2] && mod_raw[module_irq_fault_input_zero + 2])
    else $error("fault edge not flagged");

  a_irq_quiet: assert property (mod_masked == '0 |=> !irq) // [R6]
    else $error("interrupt raised with nothing unmasked");

  // Bus answer: exactly one wait state, ready lasts one cycle
  a_ready_follows: assert property (psel && penable && !pready |=> pready)
    else $error("ready did not follow the access phase");

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood for more than one cycle");

  // Unmapped offsets answer with an error instead of a silent zero
  a_err_unmapped: assert property (psel && penable && !pready && !hit |=> pslverr)
    else $error("unmapped access completed without error");

  // A clear that meets a new event must lose, or the event is lost
  a_set_wins: assert property (wr_fire && blk == GEN_BLK0 && ofs == OFS_ISC // [R12]
      && pwdata[gen_irq_count_at_zero] && gevt[0][gen_irq_count_at_zero]
      |=> st_reg.raw[0][gen_irq_count_at_zero])
    else $error("clear beat a same-cycle event");

  // Flags stay set until software clears them
  a_raw_sticky: assert property (st_reg.raw[0][gen_irq_count_at_zero] // [R12]
      && !(wr_fire && blk == GEN_BLK0 && ofs == OFS_ISC)
      |=> st_reg.raw[0][gen_irq_count_at_zero])
    else $error("status flag dropped without a clear");

  // Register writes land on the completing edge, the last one wins
  a_period_write: assert property (wr_fire && blk == GEN_BLK0 && ofs == OFS_PERIOD // [R10]
      |=> st_reg.period[0] == $past(pwdata[PW-1:0]))
    else $error("last period write not kept");

  a_inten_write: assert property (wr_fire && blk == GEN_BLK0 && ofs == OFS_INTEN // [R4]
      |=> st_reg.inten[0] == $past(pwdata[INTEN_W-1:0]))
    else $error("enable write not taken");

  a_mod_enable: assert property (wr_fire && paddr == OFS_MOD_EN // [R6]
      |=> st_reg.gen_en == $past(pwdata[module_irq_generator_zero +: NGEN])
      && st_reg.flt_en == $past(pwdata[module_irq_fault_input_zero +: NFLT]))
    else $error("module enable write not taken");

  // Enabled source shows in the masked view
  a_gen_unmask: assert property (st_reg.inten[0][gen_irq_cmp_a_falling_count] // [R4]
      && st_reg.raw[0][gen_irq_cmp_a_falling_count]
      |-> gmasked[0][gen_irq_cmp_a_falling_count])
    else $error("enabled source missing from masked view");

  // Fault flag clears by one, unless a new edge arrives in the same cycle
  a_fault_clear: assert property (wr_fire && paddr == OFS_MOD_ISC // [R7]
      && pwdata[module_irq_fault_input_zero + 2]
      && !(st_reg.fsync2[2] && !st_reg.fprev[2])
      |=> !st_reg.flt_raw[2])
    else $error("write one did not clear fault flag");

  // Enabled trigger pulses on its event
  a_trig_pulse: assert property (gevt[0][gen_irq_count_at_zero] // [R5]
      && st_reg.inten[0][gen_trig_count_at_zero]
      |=> trig[0][gen_irq_count_at_zero])
    else $error("enabled trigger did not pulse");

  // Trigger stays quiet while only its interrupt twin may be enabled
  a_trig_masked: assert property ( // [R5]
      !st_reg.inten[0][gen_trig_count_at_zero + gen_irq_count_at_load]
      |=> !trig[0][gen_irq_count_at_load])
    else $error("disabled trigger still pulsed");

  // Main scenarios the bench is expected to reach
  c_irq_raised: cover property (!irq ##1 irq);
  c_flag_cleared: cover property (st_reg.raw[0][gen_irq_count_at_zero]
      ##1 !st_reg.raw[0][gen_irq_count_at_zero]);
  c_trig_pulse: cover property (trig[0][gen_irq_count_at_zero]);
  c_unmapped: cover property (pready && pslverr);
  c_fault_flag: cover property (st_reg.flt_raw != '0);
endmodule // pwm_irq_trig_period

// [tb/cpu_apb_model.sv]
/*
  Processor-side model: an APB master that runs one transfer at a time.
  Assumes the slave raises pready within 20 cycles of the access phase.
*/
`timescale 1ns/10ps
module cpu_apb_model
  import pwm_irq_pkg::*;
(
  input  wire logic          clk,
  output logic               psel,
  output logic               penable,
  output logic               pwrite,
  output logic [AW-1:0]      paddr,
  output logic [31:0]        pwdata,
  input  wire logic [31:0]   prdata,
  input  wire logic          pready,
  input  wire logic          pslverr
);
  logic timed_out;
  logic last_err;

  // Idle bus from time zero
  initial
  begin
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = '0;
    timed_out = 1'b0;
    last_err  = 1'b0;
  end

  // Setup, access, hold until pready is seen at an edge, then release
  task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    last_err = pslverr;
    if (n >= 20)
      timed_out = 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // cpu_apb_model

// [tb/tb_top.sv]
/*
  Testbench for the PWM interrupt, trigger and period block, generator 0.
  Assumes the processor model drives APB and this module drives the rest.
*/
`timescale 1ns/10ps
module tb_top
  import pwm_irq_pkg::*;
;
  logic                      clk;
  logic                      rst;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [AW-1:0]             paddr;
  logic [31:0]               pwdata;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  logic [NFLT-1:0]           fault_in;
  logic [NGEN-1:0][NEVT-1:0] trig;
  logic                      irq;
  int                        num_errors;
  int                        n_compared;

  pwm_irq_trig_period dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_in(fault_in), .trig(trig), .irq(irq));
  cpu_apb_model cpu_u (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [AW-1:0] ga(input int g, input logic [5:0] ofs);
    return {6'(GEN_BLK0 + g), ofs};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict;
    $display("compared=%0d errors=%0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A hung bus ends the run at once
  task automatic acc(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    cpu_u.xfer(w, a, d, r);
    if (cpu_u.timed_out)
    begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask

  // Ticks between two counter-zero trigger pulses, bounded
  task automatic measure(output int n);
    int k;
    k = 0;
    n = 0;
    do
    begin
      @(posedge clk);
      k++;
    end while (trig[0][0] !== 1'b1 && k < 100);
    do
    begin
      @(posedge clk);
      n++;
    end while (trig[0][0] !== 1'b1 && n < 100);
    // A missing pulse ends the run at once
    if (k >= 100 || n >= 100)
    begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic t_reset;
    logic [31:0] r;
    rdc(ga(0, OFS_PERIOD), 32'h0);
    rdc(ga(3, OFS_INTEN), 32'h0);
    rdc(OFS_MOD_EN, 32'h0);
    acc(1'b0, 12'h00C, 32'h0, r);
    chk(r, 32'h0);
    chk(cpu_u.last_err, 32'h1);
  endtask

  // Buffered period, triggers gated by their own enables
  task automatic t_period;
    int          n;
    logic [5:0]  seen;
    wr(ga(0, OFS_PERIOD), 32'h5);
    wr(ga(0, OFS_PERIOD), 32'h7);
    rdc(ga(0, OFS_PERIOD), 32'h7);
    wr(ga(0, OFS_INTEN), 32'h2100);
    wr(ga(0, OFS_CMPA), 32'h2);
    wr(ga(0, OFS_CMPB), 32'h3);
    wr(ga(0, OFS_CTL), 32'h1);
    measure(n);
    chk(n, 32'h7);
    wr(ga(0, OFS_PERIOD), 32'h4);
    rdc(ga(0, OFS_PERIOD), 32'h4);
    measure(n);
    measure(n);
    chk(n, 32'h4);
    seen = '0;
    repeat (30)
    begin
      @(posedge clk);
      seen |= trig[0];
    end
    chk(seen, 32'h21);
    rdc(ga(0, OFS_RIS), 32'h2B);
    rdc(ga(0, OFS_ISC), 32'h0);
  endtask

  // Up/down gives the rising compare events; then clear by ones only
  task automatic t_updown;
    wr(ga(0, OFS_PERIOD), 32'h8);
    wr(ga(0, OFS_CTL), 32'h3);
    repeat (40) @(posedge clk);
    rdc(ga(0, OFS_RIS), 32'h3F);
    wr(ga(0, OFS_CTL), 32'h0);
    wr(ga(0, OFS_ISC), 32'h0);
    rdc(ga(0, OFS_RIS), 32'h3F);
    wr(ga(0, OFS_ISC), 32'h2);
    rdc(ga(0, OFS_RIS), 32'h3D);
  endtask

  task automatic t_irq;
    wr(ga(0, OFS_INTEN), 32'h0C);
    rdc(ga(0, OFS_ISC), 32'h0C);
    wr(OFS_MOD_EN, 32'h0);
    rdc(OFS_MOD_RIS, 32'h1);
    rdc(OFS_MOD_ISC, 32'h0);
    chk(irq, 32'h0);
    wr(OFS_MOD_EN, 32'h1);
    repeat (3) @(posedge clk);
    chk(irq, 32'h1);
    rdc(OFS_MOD_ISC, 32'h1);
    wr(ga(0, OFS_INTEN), 32'h2);
    rdc(ga(0, OFS_ISC), 32'h0);
    rdc(OFS_MOD_RIS, 32'h0);
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
  endtask

  task automatic t_fault;
    wr(OFS_MOD_EN, 32'h40000);
    @(posedge clk);
    fault_in <= 4'h4;
    repeat (5) @(posedge clk);
    rdc(OFS_MOD_RIS, 32'h40000);
    chk(irq, 32'h1);
    wr(OFS_MOD_ISC, 32'h40000);
    rdc(OFS_MOD_RIS, 32'h0);
    repeat (3) @(posedge clk);
    chk(irq, 32'h0);
  endtask

  // Main sequence: reset held 10 cycles, then the scenarios
  initial
  begin
    num_errors = 0;
    n_compared = 0;
    rst = 1'b1;
    fault_in = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_period();
    t_updown();
    t_irq();
    t_fault();
    print_verdict();
  end
endmodule // tb_top
